// [design/fcc_map.svh]
`ifndef FCC_MAP_SVH
`define FCC_MAP_SVH

// bits handled by one logic cell (two function generators)
`define FCC_CELL_BITS   2
// carry and sum value after reset
`define FCC_RST_BIT     1'b0
`define FCC_RST_SUM     2'h0

`endif

// [design/fcc_pkg.sv]
package fcc_pkg;

  // static configuration of one logic cell
  typedef struct packed {
    logic high_cap;       // 1: high-capacity variant, 0: base variant
    logic dir_down;       // base variant only: chain runs downward
    logic subtract;       // borrow mode, operand b inverted
    logic init_zero_sel;  // high-capacity: zero choice on input-four selector
    logic col_top;        // cell sits at the top of its column
    logic col_bottom;     // cell sits at the bottom of its column
  } fcc_cfg_type;

  // operand bits shared with the two function generators
  typedef struct packed {
    logic [1:0] op_a;
    logic [1:0] op_b;
  } fcc_opnd_type;

  // all registered state of the cell
  typedef struct packed {
    logic [1:0] sum;
    logic       carry_up;
    logic       carry_down;
    logic       carry_right;
  } fcc_state_type;

endpackage

// [design/fcc_cell.sv]
`timescale 1ns/1ns
// Functional notes
// - each generator has its own carry/borrow logic feeding the next generator directly.
// - the two generators of a cell form a 2-bit adder with internal carry; cells cascade.
// - in the base variant the chain can run upward or downward through a column.
// - in the base variant the carry passes sideways to the right column at a column end.
// - the high-capacity chain runs upward only; downward carries use general routing.
// - a high-capacity cell carries out only at the top and has no downward carry input.
// - high-capacity zero choice on input four lets that input drive the carry directly.
// - the carry logic shares the generator operands and its carries feed the sums.
// - in the high-capacity variant the pass-through carry has no direction selector.
`include "fcc_map.svh"

module fcc_cell (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset_n,
  // configuration
  input  wire fcc_pkg::fcc_cfg_type  cfg,
  // operands
  input  wire fcc_pkg::fcc_opnd_type opnd,
  input  wire logic                 second_gen_input_four,
  // carries from neighbouring cells
  input  wire logic                 carry_from_below,
  input  wire logic                 downward_carry_input,
  input  wire logic                 side_carry_input,
  // results
  output logic [1:0]                sum_out,
  output logic                      carry_output,
  output logic                      carry_output_down,
  output logic                      carry_right
);

  fcc_pkg::fcc_state_type state_reg;
  fcc_pkg::fcc_state_type state_next;

  logic                        carry_in;
  logic [`FCC_CELL_BITS:0]     chain;
  logic [`FCC_CELL_BITS-1:0]   sum_c;

  // carry-in source selection
  always_comb begin
    if (cfg.high_cap) begin
      // single upward path, no direction selector in the pass-through
      carry_in = cfg.init_zero_sel ? second_gen_input_four : carry_from_below;
    end else if (cfg.dir_down) begin
      // entering at the top of a column, the carry arrives from the side
      carry_in = cfg.col_top ? side_carry_input : downward_carry_input;
    end else begin
      carry_in = cfg.col_bottom ? side_carry_input : carry_from_below;
    end
  end

  assign chain[0] = carry_in;

  // one full adder stage per function generator
  genvar gi;
  generate
    for (gi = 0; gi < `FCC_CELL_BITS; gi = gi + 1) begin : g_bit
      logic opb;
      assign opb          = opnd.op_b[gi] ^ cfg.subtract;
      assign sum_c[gi]    = opnd.op_a[gi] ^ opb ^ chain[gi];
      assign chain[gi+1]  = (opnd.op_a[gi] & opb) | (opnd.op_a[gi] & chain[gi])
                          | (opb & chain[gi]);
    end
  endgenerate

  // route the cell carry out upward, downward or to the right neighbour
  always_comb begin
    state_next             = state_reg;
    state_next.sum         = sum_c;
    state_next.carry_up    = `FCC_RST_BIT;
    state_next.carry_down  = `FCC_RST_BIT;
    state_next.carry_right = `FCC_RST_BIT;
    if (cfg.high_cap) begin
      state_next.carry_up = chain[`FCC_CELL_BITS];
    end else if (cfg.dir_down) begin
      if (cfg.col_bottom) begin
        state_next.carry_right = chain[`FCC_CELL_BITS];
      end else begin
        state_next.carry_down = chain[`FCC_CELL_BITS];
      end
    end else begin
      if (cfg.col_top) begin
        state_next.carry_right = chain[`FCC_CELL_BITS];
      end else begin
        state_next.carry_up = chain[`FCC_CELL_BITS];
      end
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_reg.sum         <= `FCC_RST_SUM;
      state_reg.carry_up    <= `FCC_RST_BIT;
      state_reg.carry_down  <= `FCC_RST_BIT;
      state_reg.carry_right <= `FCC_RST_BIT;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state register
  assign sum_out           = state_reg.sum;
  assign carry_output      = state_reg.carry_up;
  assign carry_output_down = state_reg.carry_down;
  assign carry_right       = state_reg.carry_right;

  // checks on registered results one cycle after the operands
  property p_gen_carry;
    @(posedge core_clk) disable iff (!reset_n)
    (!cfg.high_cap && !cfg.dir_down && !cfg.col_top && !cfg.col_bottom && !cfg.subtract
     && opnd.op_a == 2'h3 && opnd.op_b == 2'h3) |=> carry_output;
  endproperty
  a_gen_carry: assert property (p_gen_carry) else $error("generated carry missing");

  property p_two_bit_add;
    @(posedge core_clk) disable iff (!reset_n)
    (cfg.high_cap && !cfg.init_zero_sel && !cfg.subtract && !carry_from_below
     && opnd.op_a == 2'h1 && opnd.op_b == 2'h1) |=> (sum_out == 2'h2 && !carry_output);
  endproperty
  a_two_bit_add: assert property (p_two_bit_add) else $error("internal carry wrong");

  property p_down_pass;
    @(posedge core_clk) disable iff (!reset_n)
    (!cfg.high_cap && cfg.dir_down && !cfg.col_top && !cfg.col_bottom && !cfg.subtract
     && opnd.op_a == 2'h3 && opnd.op_b == 2'h0)
    |=> (carry_output_down == $past(downward_carry_input) && !carry_output);
  endproperty
  a_down_pass: assert property (p_down_pass) else $error("downward chain broken");

  property p_side_exit;
    @(posedge core_clk) disable iff (!reset_n)
    (!cfg.high_cap && !cfg.dir_down && cfg.col_top && !cfg.col_bottom && !cfg.subtract
     && opnd.op_a == 2'h3 && opnd.op_b == 2'h0)
    |=> (carry_right == $past(carry_from_below) && !carry_output);
  endproperty
  a_side_exit: assert property (p_side_exit) else $error("column end carry not sideways");

  property p_up_only;
    @(posedge core_clk) disable iff (!reset_n)
    cfg.high_cap |=> (!carry_output_down && !carry_right);
  endproperty
  a_up_only: assert property (p_up_only) else $error("high-cap carry left downward");

  property p_init_path;
    @(posedge core_clk) disable iff (!reset_n)
    (cfg.high_cap && cfg.init_zero_sel && !cfg.subtract && opnd.op_a == 2'h3
     && opnd.op_b == 2'h0) |=> (carry_output == $past(second_gen_input_four));
  endproperty
  a_init_path: assert property (p_init_path) else $error("input four not driving carry");

  property p_borrow;
    @(posedge core_clk) disable iff (!reset_n)
    (cfg.high_cap && !cfg.init_zero_sel && cfg.subtract && carry_from_below
     && opnd.op_a == 2'h2 && opnd.op_b == 2'h2) |=> (sum_out == 2'h0 && carry_output);
  endproperty
  a_borrow: assert property (p_borrow) else $error("subtract result wrong");

  property p_no_dir_mux;
    @(posedge core_clk) disable iff (!reset_n)
    (cfg.high_cap && !cfg.init_zero_sel && !cfg.subtract && opnd.op_a == 2'h3
     && opnd.op_b == 2'h0) |=> (carry_output == $past(carry_from_below));
  endproperty
  a_no_dir_mux: assert property (p_no_dir_mux) else $error("pass-through carry wrong");

  property p_full_add;
    @(posedge core_clk) disable iff (!reset_n)
    (cfg.high_cap && !cfg.init_zero_sel && !cfg.subtract && carry_from_below
     && opnd.op_a == 2'h1 && opnd.op_b == 2'h0) |=> (sum_out == 2'h2 && !carry_output);
  endproperty
  a_full_add: assert property (p_full_add) else $error("sum or majority carry wrong");

  property p_side_entry;
    @(posedge core_clk) disable iff (!reset_n)
    (!cfg.high_cap && !cfg.dir_down && !cfg.col_top && cfg.col_bottom && !cfg.subtract
     && opnd.op_a == 2'h3 && opnd.op_b == 2'h0)
    |=> (carry_output == $past(side_carry_input) && !carry_right);
  endproperty
  a_side_entry: assert property (p_side_entry) else $error("side carry not entering");

  property p_down_entry;
    @(posedge core_clk) disable iff (!reset_n)
    (!cfg.high_cap && cfg.dir_down && cfg.col_top && !cfg.col_bottom && !cfg.subtract
     && opnd.op_a == 2'h3 && opnd.op_b == 2'h0)
    |=> (carry_output_down == $past(side_carry_input) && !carry_output);
  endproperty
  a_down_entry: assert property (p_down_entry) else $error("downward entry wrong");

  property p_down_exit;
    @(posedge core_clk) disable iff (!reset_n)
    (!cfg.high_cap && cfg.dir_down && !cfg.col_top && cfg.col_bottom && !cfg.subtract
     && opnd.op_a == 2'h3 && opnd.op_b == 2'h0)
    |=> (carry_right == $past(downward_carry_input) && !carry_output_down);
  endproperty
  a_down_exit: assert property (p_down_exit) else $error("bottom carry not sideways");

  property p_one_exit;
    @(posedge core_clk) disable iff (!reset_n)
    !cfg.high_cap |=> $onehot0({carry_output, carry_output_down, carry_right});
  endproperty
  a_one_exit: assert property (p_one_exit) else $error("base carry on two exits");

  property p_down_no_up;
    @(posedge core_clk) disable iff (!reset_n)
    (!cfg.high_cap && cfg.dir_down) |=> !carry_output;
  endproperty
  a_down_no_up: assert property (p_down_no_up) else $error("downward chain left at top");

  property p_up_no_down;
    @(posedge core_clk) disable iff (!reset_n)
    (!cfg.high_cap && !cfg.dir_down) |=> !carry_output_down;
  endproperty
  a_up_no_down: assert property (p_up_no_down) else $error("upward chain left at bottom");

  property p_init_borrow;
    @(posedge core_clk) disable iff (!reset_n)
    (cfg.high_cap && cfg.init_zero_sel && cfg.subtract && second_gen_input_four
     && opnd.op_a == 2'h2 && opnd.op_b == 2'h2) |=> (sum_out == 2'h0 && carry_output);
  endproperty
  a_init_borrow: assert property (p_init_borrow) else $error("borrow init wrong");

endmodule

// [sim/fcc_neighbour.sv]
`timescale 1ns/1ns
// neighbouring cells: carry on the chosen line, other lines scrambled
module fcc_neighbour (
  // clock
  input  wire logic       core_clk,
  // carry wanted by the bench, route 0 below 1 above 2 side 3 none
  input  wire logic [1:0] route,
  input  wire logic       cin,
  // carries into the cell
  output logic            carry_from_below,
  output logic            downward_carry_input,
  output logic            side_carry_input
);
  logic junk_reg = 1'h0;
  // unused lines flip every cycle so an ignored input cannot match by luck
  always @(posedge core_clk) junk_reg <= ~junk_reg;
  // drive the selected carry
  always_comb begin
    carry_from_below     = (route == 2'h0) ? cin : junk_reg;
    downward_carry_input = (route == 2'h1) ? cin : ~junk_reg;
    side_carry_input     = (route == 2'h2) ? cin : junk_reg;
  end
endmodule

// [sim/fcc_cell_bench.sv]
`timescale 1ns/1ns
module fcc_cell_bench;
  logic                  core_clk, reset_n, init_in, cin, cf_b, cf_d, cf_s;
  logic                  carry_output, carry_output_down, carry_right;
  logic [1:0]            route, sum_out;
  fcc_pkg::fcc_cfg_type  cfg;
  fcc_pkg::fcc_opnd_type opnd;
  int                    n_mismatch = 0, tests_run = 0, cycles = 0;

  fcc_cell u_fcc_cell (.core_clk(core_clk), .reset_n(reset_n), .cfg(cfg), .opnd(opnd),
    .second_gen_input_four(init_in), .carry_from_below(cf_b), .downward_carry_input(cf_d),
    .side_carry_input(cf_s), .sum_out(sum_out), .carry_output(carry_output),
    .carry_output_down(carry_output_down), .carry_right(carry_right));
  fcc_neighbour u_fcc_neighbour (.core_clk(core_clk), .route(route), .cin(cin),
    .carry_from_below(cf_b), .downward_carry_input(cf_d), .side_carry_input(cf_s));

  // clock and hang guard
  initial begin
    core_clk = 1'h0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task give_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task chk(input string what, input logic [4:0] exp, input logic [4:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one cell operation: c = {high_cap, dir_down, subtract, init, top, bottom}
  task run(input logic [5:0] c, input logic [1:0] a, b, input logic g, ci);
    logic [2:0] s;
    logic [4:0] e;
    logic       cv;
    cfg = c;
    opnd = {a, b};
    init_in = g;
    cin = ci;
    cv = (c[5] && c[2]) ? g : ci;
    // high-capacity cells always see ci from below, so the init path must win against it
    route = c[5] ? 2'h0 : (c[4] ? (c[1] ? 2'h2 : 2'h1) : (c[0] ? 2'h2 : 2'h0));
    s = {1'h0, a} + {1'h0, b ^ {2{c[3]}}} + {2'h0, cv};
    e = {s[1:0], 3'h0};
    if (c[5] || (!c[4] && !c[1]))
      e[2] = s[2];
    else if (c[4] && !c[0])
      e[1] = s[2];
    else
      e[0] = s[2];
    @(negedge core_clk);
    chk("cell", e, {sum_out, carry_output, carry_output_down, carry_right});
  endtask

  // high-capacity add and subtract, every operand and carry
  task t_high();
    for (int i = 0; i < 64; i++)
      run({2'h2, i[5], 3'h0}, i[1:0], i[3:2], ~i[4], i[4]);
  endtask

  // carry-in from the input-four path
  task t_init();
    run(6'h24, 2'h3, 2'h0, 1'h1, 1'h0);
    run(6'h2C, 2'h2, 2'h2, 1'h1, 1'h0);
    run(6'h24, 2'h1, 2'h1, 1'h0, 1'h1);
  endtask

  // base variant: both directions, top, middle and bottom of a column (never top and bottom at once)
  task t_base();
    for (int i = 0; i < 16; i++)
      if (i[3:2] != 2'h3)
        run({1'h0, i[0], 1'h0, i[1], i[3:2]}, 2'h3, 2'h0, ~i[1], i[1]);
    run(6'h00, 2'h3, 2'h3, 1'h0, 1'h1);
  endtask

  // reset in mid-run clears everything
  task t_reset();
    run(6'h20, 2'h3, 2'h3, 1'h0, 1'h1);
    reset_n = 1'h0;
    @(negedge core_clk);
    chk("reset", 5'h00, {sum_out, carry_output, carry_output_down, carry_right});
    reset_n = 1'h1;
  endtask

  initial begin
    reset_n = 1'h0;
    cfg = '0;
    opnd = '0;
    init_in = 1'h0;
    cin = 1'h0;
    route = 2'h0;
    repeat (6) @(negedge core_clk);
    reset_n = 1'h1;
    t_high();
    t_init();
    t_base();
    t_reset();
    t_high();
    give_verdict();
  end
endmodule
